// [inc/smcp_pkg.sv]
`default_nettype none

package smcp_pkg;

  // ----------------------------------------------------------------
  // Session layout
  // ----------------------------------------------------------------
  localparam int       BYTE_W       = 8;
  localparam int       CMD_ADDR_W   = 5;
  localparam int       BIT_CNT_W    = 4;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [3:0] LAST_SLOT  = 4'hF;
  localparam logic [3:0] FIRST_DATA = 4'h8;
  localparam logic     RW_READ      = 1'b1;
  localparam logic     RW_WRITE     = 1'b0;

  // ----------------------------------------------------------------
  // Pin synchroniser vector {sclk, cs_n, io, in} and its reset value
  // ----------------------------------------------------------------
  localparam int         PIN_SCLK = 3;
  localparam int         PIN_CS_N = 2;
  localparam int         PIN_IO   = 1;
  localparam int         PIN_IN   = 0;
  localparam logic [3:0] PIN_RST  = 4'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 20;
  localparam int LINK_NS     = 320;
  localparam int HALF_CYC    = (LINK_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int HALF_CNT_W  = 8;

  typedef enum logic [1:0] {
    SMCP_DEV_IDLE,
    SMCP_DEV_CMD,
    SMCP_DEV_DATA,
    SMCP_DEV_DONE
  } smcp_dev_state_type;

  typedef enum logic [2:0] {
    SMCP_HOST_IDLE,
    SMCP_HOST_PRE,
    SMCP_HOST_SEL,
    SMCP_HOST_LOW,
    SMCP_HOST_HIGH,
    SMCP_HOST_END,
    SMCP_HOST_GAP
  } smcp_host_state_type;

endpackage

`default_nettype wire

// [inc/smcp_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface smcp_if;
  logic sclk;
  logic cs_n;
  logic serial_in_line;
  logic io_dev_out;
  logic io_dev_oe;
  logic io_host_out;
  logic io_host_oe;
  logic serial_io_line;

  // Shared line with a weak pull-up when nobody drives
  assign serial_io_line = io_dev_oe ? io_dev_out : (io_host_oe ? io_host_out : 1'b1);

  modport dev (
    input  sclk,
    input  cs_n,
    input  serial_in_line,
    input  serial_io_line,
    output io_dev_out,
    output io_dev_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output serial_in_line,
    output io_host_out,
    output io_host_oe,
    input  serial_io_line
  );
endinterface

`default_nettype wire

// [rtl/smcp_device.sv]
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Sample clock level at select activation
// - Clock high: LSB-first, shared line only
// - Clock low: MSB-first, separate in/out lines
// - Host uses polarity zero, phase zero in MSB mode; in LSB mode the clock idles high
// - Host discards bits read during writes
// - Ignore host bits during a read
// - Access is command byte plus data
// - Host holds select for whole session
// - First eight clocks carry command byte
// - Decode direction and address from command
// - Next eight clocks carry the data
// - Select high releases the shared line
// - Data bit order follows the mode
// - Command layout differs per mode
// - Sample on rise, present on fall
module smcp_device
  import smcp_pkg::*;
#(
  parameter int ADDR_W = CMD_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  smcp_if.dev                    link,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [BYTE_W-1:0]      reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd,
  input  wire logic [BYTE_W-1:0] reg_rdata,
  output logic                   mode_lsb
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_f;
  logic [3:0] pin_prev;

  assign pin_raw = {link.sclk, link.cs_n, link.serial_io_line, link.serial_in_line};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= PIN_RST;
      pin_s2 <= PIN_RST;
      pin_s3 <= PIN_RST;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_f    <= PIN_RST;
      pin_prev <= PIN_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_f[i] <= pin_s2[i];
        end
      end
      pin_prev <= pin_f;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and data pin selection
  // ----------------------------------------------------------------
  logic cs_fall;
  logic cs_high;
  logic sclk_rise;
  logic sclk_fall;
  logic din;

  assign cs_high   = pin_f[PIN_CS_N];
  assign cs_fall   = pin_prev[PIN_CS_N] & ~pin_f[PIN_CS_N];
  assign sclk_rise = ~pin_prev[PIN_SCLK] & pin_f[PIN_SCLK];
  assign sclk_fall = pin_prev[PIN_SCLK] & ~pin_f[PIN_SCLK];
  // Shared line carries input in LSB mode; the input line is ignored there
  assign din       = mode_lsb ? pin_f[PIN_IO] : pin_f[PIN_IN];

  // ----------------------------------------------------------------
  // Session sequencing
  // ----------------------------------------------------------------
  smcp_dev_state_type        state;
  logic [BIT_CNT_W-1:0]      bit_cnt;
  logic [BYTE_W-1:0]         cmd_seq;
  logic [BYTE_W-1:0]         data_seq;
  logic [BYTE_W-1:0]         next_cmd_seq;
  logic [BYTE_W-1:0]         next_data_seq;
  logic                      rw;

  assign next_cmd_seq  = {cmd_seq[BYTE_W-2:0], din};
  assign next_data_seq = {data_seq[BYTE_W-2:0], din};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state   <= SMCP_DEV_IDLE;
      bit_cnt <= '0;
    end else if (cs_high) begin
      state   <= SMCP_DEV_IDLE;
      bit_cnt <= '0;
    end else begin
      case (state)
        SMCP_DEV_IDLE: begin
          if (cs_fall) begin
            state   <= SMCP_DEV_CMD;
            bit_cnt <= '0;
          end
        end
        SMCP_DEV_CMD: begin
          if (sclk_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == LAST_BIT) begin
              state   <= SMCP_DEV_DATA;
              bit_cnt <= '0;
            end
          end
        end
        SMCP_DEV_DATA: begin
          if (sclk_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == LAST_BIT) begin
              state <= SMCP_DEV_DONE;
            end
          end
        end
        SMCP_DEV_DONE: begin
          state <= SMCP_DEV_DONE;
        end
        default: begin
          state <= SMCP_DEV_IDLE;
        end
      endcase
    end
  end

  // Mode latched from the clock level as select activates
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_lsb <= 1'b0;
    end else if (state == SMCP_DEV_IDLE && cs_fall) begin
      mode_lsb <= pin_f[PIN_SCLK];
    end
  end

  // Shift registers collect bits in arrival order
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_seq  <= '0;
      data_seq <= '0;
    end else if (sclk_rise) begin
      if (state == SMCP_DEV_CMD) begin
        cmd_seq <= next_cmd_seq;
      end
      if (state == SMCP_DEV_DATA) begin
        data_seq <= next_data_seq;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode and register access
  // ----------------------------------------------------------------
  // First bit is the direction, then the address in the mode's bit order
  logic [ADDR_W-1:0] addr_arrival;
  logic [ADDR_W-1:0] addr_dec;
  logic [BYTE_W-1:0] wdata_dec;

  assign addr_arrival = next_cmd_seq[BYTE_W-2 -: ADDR_W];

  always_comb begin
    addr_dec  = addr_arrival;
    wdata_dec = next_data_seq;
    if (mode_lsb) begin
      for (int i = 0; i < ADDR_W; i++) begin
        addr_dec[i] = addr_arrival[ADDR_W-1-i];
      end
      for (int i = 0; i < BYTE_W; i++) begin
        wdata_dec[i] = next_data_seq[BYTE_W-1-i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rw       <= RW_WRITE;
      reg_addr <= '0;
      reg_rd   <= 1'b0;
    end else begin
      reg_rd <= 1'b0;
      if (state == SMCP_DEV_CMD && sclk_rise && bit_cnt == LAST_BIT && !cs_high) begin
        rw       <= next_cmd_seq[BYTE_W-1];
        reg_addr <= addr_dec;
        reg_rd   <= (next_cmd_seq[BYTE_W-1] == RW_READ);
      end
    end
  end

  // Write strobe only once the eighth data bit is in
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_wr    <= 1'b0;
      reg_wdata <= '0;
    end else begin
      reg_wr <= 1'b0;
      if (state == SMCP_DEV_DATA && sclk_rise && bit_cnt == LAST_BIT && !cs_high
          && rw == RW_WRITE) begin
        reg_wr    <= 1'b1;
        reg_wdata <= wdata_dec;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data return
  // ----------------------------------------------------------------
  logic              tx_load;
  logic [BYTE_W-1:0] tx_shift;
  logic [BYTE_W-1:0] rdata_ord;

  always_comb begin
    rdata_ord = reg_rdata;
    if (mode_lsb) begin
      for (int i = 0; i < BYTE_W; i++) begin
        rdata_ord[i] = reg_rdata[BYTE_W-1-i];
      end
    end
  end

  // Register data is taken the cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_load  <= 1'b0;
      tx_shift <= '0;
    end else begin
      tx_load <= reg_rd;
      if (tx_load) begin
        tx_shift <= rdata_ord;
      end else if (state == SMCP_DEV_DATA && rw == RW_READ && sclk_fall) begin
        tx_shift <= {tx_shift[BYTE_W-2:0], 1'b0};
      end
    end
  end

  // Host bits during a read are shifted in but never used
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.io_dev_out <= 1'b1;
      link.io_dev_oe  <= 1'b0;
    end else if (cs_high) begin
      link.io_dev_oe <= 1'b0;
    end else if (state == SMCP_DEV_DATA && rw == RW_READ && sclk_fall) begin
      link.io_dev_out <= tx_shift[BYTE_W-1];
      link.io_dev_oe  <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// [rtl/smcp_host.sv]
`timescale 1ns/10ps
`default_nettype none

module smcp_host
  import smcp_pkg::*;
#(
  parameter int ADDR_W    = CMD_ADDR_W,
  parameter int HALF_CLKS = HALF_CYC
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  smcp_if.host                   link,
  input  wire logic              start,
  input  wire logic              lsb_mode,
  input  wire logic              rw,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [BYTE_W-1:0] wdata,
  output logic                   busy,
  output logic                   done,
  output logic [BYTE_W-1:0]      rdata
);

  // ----------------------------------------------------------------
  // Shared line synchroniser
  // ----------------------------------------------------------------
  logic io_s1;
  logic io_s2;
  logic io_s3;
  logic io_f;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_s1 <= 1'b1;
      io_s2 <= 1'b1;
      io_s3 <= 1'b1;
      io_f  <= 1'b1;
    end else begin
      io_s1 <= link.serial_io_line;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      if (io_s2 == io_s3) begin
        io_f <= io_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame assembly in arrival order
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0]   addr_ord;
  logic [BYTE_W-1:0]   data_ord;
  logic [2*BYTE_W-1:0] frame;

  always_comb begin
    addr_ord = addr;
    data_ord = wdata;
    if (lsb_mode) begin
      for (int i = 0; i < ADDR_W; i++) begin
        addr_ord[i] = addr[ADDR_W-1-i];
      end
      for (int i = 0; i < BYTE_W; i++) begin
        data_ord[i] = wdata[BYTE_W-1-i];
      end
    end
    frame = {rw, addr_ord, {(BYTE_W-1-ADDR_W){1'b0}}, data_ord};
  end

  // ----------------------------------------------------------------
  // Clock divider and sequencing
  // ----------------------------------------------------------------
  smcp_host_state_type   state;
  logic [HALF_CNT_W-1:0] hcnt;
  logic                  tick;
  logic [BIT_CNT_W-1:0]  bcnt;
  logic [2*BYTE_W-1:0]   tx;
  logic [BYTE_W-1:0]     rx;
  logic                  lsb;
  logic                  rd;

  assign tick = (hcnt == HALF_CNT_W'(HALF_CLKS - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hcnt <= '0;
    end else if (state == SMCP_HOST_IDLE || tick) begin
      hcnt <= '0;
    end else begin
      hcnt <= hcnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state               <= SMCP_HOST_IDLE;
      bcnt                <= '0;
      tx                  <= '0;
      rx                  <= '0;
      lsb                 <= 1'b0;
      rd                  <= 1'b0;
      busy                <= 1'b0;
      done                <= 1'b0;
      rdata               <= '0;
      link.sclk           <= 1'b0;
      link.cs_n           <= 1'b1;
      link.serial_in_line <= 1'b0;
      link.io_host_out    <= 1'b1;
      link.io_host_oe     <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        SMCP_HOST_IDLE: begin
          if (start) begin
            state     <= SMCP_HOST_PRE;
            busy      <= 1'b1;
            lsb       <= lsb_mode;
            rd        <= rw;
            tx        <= frame;
            bcnt      <= '0;
            link.sclk <= lsb_mode;
          end
        end
        SMCP_HOST_PRE: begin
          if (tick) begin
            link.cs_n <= 1'b0;
            state     <= SMCP_HOST_SEL;
          end
        end
        SMCP_HOST_SEL, SMCP_HOST_HIGH: begin
          if (tick) begin
            if (state == SMCP_HOST_HIGH && bcnt >= FIRST_DATA) begin
              rx <= {rx[BYTE_W-2:0], io_f};
            end
            if (state == SMCP_HOST_HIGH && bcnt == LAST_SLOT) begin
              link.sclk <= lsb;
              state     <= SMCP_HOST_END;
            end else begin
              if (state == SMCP_HOST_HIGH) begin
                bcnt <= bcnt + 1'b1;
              end
              link.sclk           <= 1'b0;
              // Input line parked low in LSB sessions, where the device ignores it
              link.serial_in_line <= tx[2*BYTE_W-1] & ~lsb;
              link.io_host_out    <= tx[2*BYTE_W-1];
              link.io_host_oe     <= lsb && !(rd && (state == SMCP_HOST_HIGH
                                     ? bcnt + 1'b1 >= FIRST_DATA : 1'b0));
              tx                  <= {tx[2*BYTE_W-2:0], 1'b0};
              state               <= SMCP_HOST_LOW;
            end
          end
        end
        SMCP_HOST_LOW: begin
          if (tick) begin
            link.sclk <= 1'b1;
            state     <= SMCP_HOST_HIGH;
          end
        end
        SMCP_HOST_END: begin
          if (tick) begin
            link.cs_n       <= 1'b1;
            link.io_host_oe <= 1'b0;
            state           <= SMCP_HOST_GAP;
          end
        end
        SMCP_HOST_GAP: begin
          if (tick) begin
            busy  <= 1'b0;
            done  <= 1'b1;
            // Bits picked up during a write are thrown away
            if (rd) begin
              rdata <= rx;
              if (lsb) begin
                for (int i = 0; i < BYTE_W; i++) begin
                  rdata[i] <= rx[BYTE_W-1-i];
                end
              end
            end
            state <= SMCP_HOST_IDLE;
          end
        end
        default: begin
          state <= SMCP_HOST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [testbench/smcp_checker.sv]
`timescale 1ns/10ps
`default_nettype none

module smcp_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in_line,
  input wire logic io_dev_out,
  input wire logic io_dev_oe,
  input wire logic io_host_out,
  input wire logic io_host_oe,
  input wire logic serial_io_line
);
  logic [4:0] rises;
  logic [3:0] hi_cnt;
  logic       mode;
  logic       prev_sclk;
  logic       prev_cs;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Session tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_sclk <= 1'b0;
      prev_cs   <= 1'b1;
      mode      <= 1'b0;
    end else begin
      prev_sclk <= sclk;
      prev_cs   <= cs_n;
      if (prev_cs && !cs_n)
        mode <= sclk;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      rises <= 5'h00;
    else if (cs_n)
      rises <= 5'h00;
    else if (sclk && !prev_sclk)
      rises <= rises + 5'h01;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      hi_cnt <= 4'h0;
    else if (!cs_n)
      hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF)
      hi_cnt <= hi_cnt + 4'h1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_no_contention: assert property (!(io_dev_oe && io_host_oe))
    else $error("both ends drive the shared line");
  a_oe_released: assert property (hi_cnt >= 4'h8 |-> !io_dev_oe)
    else $error("device drives shared line while deselected");
  a_oe_drop_bound: assert property ($rose(cs_n) |-> ##[1:8] !io_dev_oe)
    else $error("device driver not released after deselect");
  a_oe_after_cmd: assert property ($rose(io_dev_oe) |-> rises >= 5'h08 && !cs_n)
    else $error("device drives before command byte is complete");
  a_msb_host_quiet: assert property (!cs_n && !mode |-> !io_host_oe)
    else $error("host drives shared line in msb mode");
  a_host_edge_count: assert property ($rose(cs_n) |-> rises == 5'h10)
    else $error("session did not carry sixteen clocks");
  a_sel_sclk_hold: assert property ($fell(cs_n) |=> $stable(sclk)[*4])
    else $error("clock moved right after select");
  a_in_stable_high: assert property (!cs_n && !mode && sclk && prev_sclk |-> $stable(serial_in_line))
    else $error("input line changed while clock high");
  a_dev_out_low: assert property (io_dev_oe && $changed(io_dev_out) |-> !sclk)
    else $error("device output changed while clock high");

  c_lsb_session: cover property ($rose(cs_n) && mode);
  c_msb_session: cover property ($rose(cs_n) && !mode);
  c_lsb_read: cover property ($rose(io_dev_oe) && mode);
  c_msb_read: cover property ($rose(io_dev_oe) && !mode);
endmodule

`default_nettype wire

// [testbench/tb_serial_control_microport.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_serial_control_microport;
  import smcp_pkg::*;
  logic                  clk;
  logic                  resetn;
  logic                  start;
  logic                  lsb_mode;
  logic                  rw;
  logic [CMD_ADDR_W-1:0] addr;
  logic [BYTE_W-1:0]     wdata;
  logic                  busy;
  logic                  done;
  logic [BYTE_W-1:0]     rdata;
  logic [CMD_ADDR_W-1:0] reg_addr;
  logic [BYTE_W-1:0]     reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [BYTE_W-1:0]     reg_rdata;
  logic                  mode_lsb;
  logic [CMD_ADDR_W-1:0] addr2;
  logic [BYTE_W-1:0]     wdata2;
  logic                  wr2;
  logic [CMD_ADDR_W-1:0] cap_addr;
  logic [BYTE_W-1:0]     cap_data;
  logic [BYTE_W-1:0]     regs [32];
  logic [BYTE_W-1:0]     shadow [32];
  logic [15:0]           bits_in;
  logic [15:0]           bits_io;
  int                    nbit = 0;
  int                    wr_cnt = 0;
  int                    wr2_cnt = 0;
  int                    rd_cnt = 0;
  logic [BYTE_W-1:0]     last_rd = 8'h00;
  int                    num_errors = 0;
  int                    num_checks = 0;

  smcp_if lnk ();
  smcp_if lnk2 ();

  smcp_host smcp_host_i (.clk(clk), .resetn(resetn), .link(lnk), .start(start), .lsb_mode(lsb_mode), .rw(rw),
    .addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
  smcp_device smcp_device_i (.clk(clk), .resetn(resetn), .link(lnk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_lsb(mode_lsb));
  smcp_device dev2_i (.clk(clk), .resetn(resetn), .link(lnk2), .reg_addr(addr2), .reg_wdata(wdata2),
    .reg_wr(wr2), .reg_rd(), .reg_rdata(8'h00), .mode_lsb());
  smcp_checker smcp_checker_i (.clk(clk), .resetn(resetn), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .serial_in_line(lnk.serial_in_line), .io_dev_out(lnk.io_dev_out), .io_dev_oe(lnk.io_dev_oe),
    .io_host_out(lnk.io_host_out), .io_host_oe(lnk.io_host_oe), .serial_io_line(lnk.serial_io_line));

  // ----------------------------------------------------------------
  // Register file behind the device, write capture and wire monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      regs[reg_addr] <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (reg_rd === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
    if (wr2 === 1'b1) begin
      wr2_cnt <= wr2_cnt + 1;
      cap_addr <= addr2;
      cap_data <= wdata2;
    end
  end

  always @(posedge clk) begin
    #1 reg_rdata = regs[reg_addr];
  end

  always @(negedge lnk.cs_n) nbit = 0;

  always @(posedge lnk.sclk) begin
    if (lnk.cs_n === 1'b0 && nbit < 16) begin
      bits_in[nbit] = lnk.serial_in_line;
      bits_io[nbit] = lnk.serial_io_line;
      nbit++;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic close_out();
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Order of bits on the wire: direction, address, two pad bits, data
  function automatic logic exp_bit(input logic m, input logic r, input logic [4:0] a, input logic [7:0] d,
                                   input int k);
    if (k == 0)
      return r;
    if (k < 6)
      return m ? a[k-1] : a[5-k];
    return m ? d[k-8] : d[15-k];
  endfunction

  task automatic access(input logic m, input logic r, input logic [4:0] a, input logic [7:0] d);
    int         k;
    int         w0;
    int         r0;
    logic [7:0] e;
    logic       b;
    w0 = wr_cnt;
    r0 = rd_cnt;
    e = r ? shadow[a] : d;
    lsb_mode = m;
    rw = r;
    addr = a;
    wdata = d;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    chk_bit("busy", 1'b1, busy);
    for (k = 0; k < 1000 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk_bit("done", 1'b1, done);
    chk_bit("busy", 1'b0, busy);
    if (r) begin
      chk_byte("read data", e, rdata);
      last_rd = e;
    end else begin
      chk_byte("kept read data", last_rd, rdata);
      shadow[a] = d;
    end
    chk_byte("write count", 8'(w0 + (r ? 0 : 1)), 8'(wr_cnt));
    chk_byte("read count", 8'(r0 + (r ? 1 : 0)), 8'(rd_cnt));
    chk_byte("register", shadow[a], regs[a]);
    chk_bit("mode", m, mode_lsb);
    chk_byte("clock count", 8'h10, 8'(nbit));
    for (k = 0; k < 16; k++) begin
      b = (m || (r && k > 7)) ? bits_io[k] : bits_in[k];
      if (k < 6 || k > 7)
        chk_bit("wire bit", exp_bit(m, r, a, e, k), b);
    end
  endtask

  // Stand-in host on the second link, msb mode, free to break the session rules
  task automatic raw_msb(input logic [19:0] s, input int n);
    int k;
    @(posedge clk);
    #1 lnk2.cs_n = 1'b0;
    for (k = 0; k < n; k++) begin
      lnk2.serial_in_line = s[19-k];
      #80 lnk2.sclk = 1'b1;
      #80 lnk2.sclk = 1'b0;
    end
    #80 lnk2.cs_n = 1'b1;
    lnk2.serial_in_line = ~lnk2.serial_in_line;
    #400;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #200000;
    num_errors++;
    close_out();
  end

  initial begin
    resetn = 1'b0;
    start = 1'b0;
    lsb_mode = 1'b0;
    rw = 1'b0;
    addr = 5'h00;
    wdata = 8'h00;
    reg_rdata = 8'h00;
    lnk2.sclk = 1'b0;
    lnk2.cs_n = 1'b1;
    lnk2.serial_in_line = 1'b0;
    lnk2.io_host_out = 1'b0;
    lnk2.io_host_oe = 1'b0;
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'(i * 7 + 3);
      shadow[i] = regs[i];
    end
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    for (int m = 0; m < 2; m++) begin
      access(m[0], 1'b1, 5'h0A, 8'h00);
      access(m[0], 1'b0, 5'h00, 8'hA5);
      access(m[0], 1'b0, 5'h1F, 8'h3C ^ 8'(m));
      access(m[0], 1'b1, 5'h1F, 8'h00);
      access(m[0], 1'b1, 5'h00, 8'hFF);
    end
    raw_msb(20'h4CC60, 12);
    chk_byte("aborted writes", 8'h00, 8'(wr2_cnt));
    raw_msb(20'h4CC6F, 20);
    chk_byte("writes", 8'h01, 8'(wr2_cnt));
    chk_byte("write address", 8'h13, {3'h0, cap_addr});
    chk_byte("write data", 8'hC6, cap_data);
    close_out();
  end
endmodule

`default_nettype wire
